/* src/timer_time_base_pkg.sv */
// constants, register map and carrier types for the timer time-base unit
// assumes a 32-bit APB master and a single 10 MHz reference clock
// Functional notes
// - 16-bit counter with reload value, counts up, down or up/down.
// - software reads and writes count, reload and prescale at any time.
// - reload writes hit a buffer; copied always, or only on update if buffered.
// - update on overflow/underflow unless inhibited, and on software request.
// - count clock gated by run bit; internal enable follows one cycle later.
// - counter keeps running while the processor is halted for debug.
// - prescaler divides by two to a 4-bit exponent via 16-bit counter.
// - prescale exponent buffered; new ratio applies from next update.
// - up mode counts 0 to reload, wraps to 0, signals overflow.
// - up mode software update restarts counter and prescale counter at 0.
// - with update-source bit set, software update does not set the flag.
// - each update loads prescale and reload shadows; all but source-only software ones set flag.
// - down mode counts reload to 0, reloads and signals underflow.
// - down mode software update reloads counter, prescale counter to 0.
// - on underflow reload, shadow refreshes before the counter reloads.
// - center mode counts 0 to reload-1, then reload down to 1.
// - center mode direction bit ignores writes, shows hardware direction.
// - center mode updates on both ends; software update restarts at 0.
// - center mode while inhibited keeps counting on the active reload.
// - timer output wins a pin when channel is output and enabled.
// - four remap bits pick port A (0) or port B (1) per channel.
// - external clock and clock gate inputs act only in external modes.
// - software update request self-clears; run stays a software bit, direction too outside center mode.
package timer_time_base_pkg;
	localparam int CNT_W = 16;
	localparam int EXP_W = 4;
	localparam int NCHAN = 4;
	localparam logic [7:0] OFS_MAIN_CONTROL  = 8'h00;
	localparam logic [7:0] OFS_EVENT_REQUEST = 8'h04;
	localparam logic [7:0] OFS_TIMER_FLAGS   = 8'h08;
	localparam logic [7:0] OFS_COUNT_VALUE   = 8'h0C;
	localparam logic [7:0] OFS_PRESCALE      = 8'h10;
	localparam logic [7:0] OFS_RELOAD_VALUE  = 8'h14;
	localparam logic [7:0] OFS_TIMER_OPTION  = 8'h18;
	localparam logic [7:0] OFS_CHANNEL_SET   = 8'h1C;
	// main_control field positions, then event, flag, option and channel field positions
	localparam int CTL_RUN    = 0;
	localparam int CTL_INHIB  = 1;
	localparam int CTL_SRC    = 2;
	localparam int CTL_DIR    = 4;
	localparam int CTL_CENTER = 5;
	localparam int CTL_RELOAD_BUFFER_ENABLE   = 7;
	localparam int CTL_EXT    = 8;
	localparam int EVT_FORCE  = 0;
	localparam int FLG_REFR   = 0;
	localparam int OPT_REMAP  = 0;
	localparam int OPT_MSKEN  = 4;
	localparam int CHS_OUT    = 0;
	localparam int CHS_EN     = 4;
	localparam logic [15:0] RELOAD_RST = 16'hFFFF;
	localparam int CLK_HZ = 10_000_000;

	typedef struct packed {
		logic ext_mode;
		logic reload_buffer_enable;
		logic center_mode;
		logic dir_down;
		logic refresh_source_only;
		logic update_inhibit;
		logic count_run_bit;
	} main_control_s;

	typedef struct packed {
		logic [NCHAN-1:0] chan_is_output;
		logic [NCHAN-1:0] chan_enable;
	} channel_set_s;
endpackage

/* src/timer_time_base.sv */
// time-base unit: apb slave, prescaler, 16-bit counter, pin routing
// assumes apb master on ref_clk; channel logic drives chan_out on the same clock
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module timer_time_base #(
	parameter int NCHAN = timer_time_base_pkg::NCHAN
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_b,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	// external clock pins (asynchronous)
	input  wire logic              ext_clock_in,
	input  wire logic              clock_gate_in,
	// channel pins and sharing
	input  wire logic [NCHAN-1:0]  pa_in,
	input  wire logic [NCHAN-1:0]  pb_in,
	input  wire logic [NCHAN-1:0]  chan_out,
	input  wire logic [NCHAN-1:0]  periph_pa_out,
	input  wire logic [NCHAN-1:0]  periph_pb_out,
	output logic [NCHAN-1:0]       chan_in,
	output logic [NCHAN-1:0]       pa_out,
	output logic [NCHAN-1:0]       pa_timer_owned,
	output logic [NCHAN-1:0]       pb_out,
	output logic [NCHAN-1:0]       pb_timer_owned,
	// time-base status
	output logic                   refresh_event,
	output logic                   internal_count_enable
);
	localparam int W = timer_time_base_pkg::CNT_W;
	localparam int EW = timer_time_base_pkg::EXP_W;

	// reset release synchroniser
	logic rst_s1_reg;
	logic rst_n;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_reg <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n      <= rst_s1_reg;
		end
	end

	// pin synchronisers: first stage is read only by the second
	logic [1:0]       ext_s1_reg;
	logic [1:0]       ext_s2_reg;
	logic             ext_prev_reg;
	logic [NCHAN-1:0] pa_s1_reg;
	logic [NCHAN-1:0] pa_s2_reg;
	logic [NCHAN-1:0] pb_s1_reg;
	logic [NCHAN-1:0] pb_s2_reg;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_s1_reg <= 2'h0;
			ext_s2_reg <= 2'h0;
			pa_s1_reg  <= '0;
			pa_s2_reg  <= '0;
			pb_s1_reg  <= '0;
			pb_s2_reg  <= '0;
		end else begin
			ext_s1_reg <= {clock_gate_in, ext_clock_in};
			ext_s2_reg <= ext_s1_reg;
			pa_s1_reg  <= pa_in;
			pa_s2_reg  <= pa_s1_reg;
			pb_s1_reg  <= pb_in;
			pb_s2_reg  <= pb_s1_reg;
		end
	end

	// registers
	timer_time_base_pkg::main_control_s ctl_reg;
	timer_time_base_pkg::channel_set_s  chs_reg;
	logic [NCHAN-1:0] remap_reg;
	logic             mask_en_reg;
	logic [W-1:0]     cnt_reg;
	logic [W-1:0]     cnt_next;
	logic [W-1:0]     arr_buf_reg;
	logic [W-1:0]     arr_act_reg;
	logic [EW-1:0]    psc_buf_reg;
	logic [EW-1:0]    psc_act_reg;
	logic [W-1:0]     psc_cnt_reg;
	logic             flag_reg;
	logic             internal_count_enable_reg;

	// apb decode
	wire acc     = psel && penable && pready;
	wire wr      = acc && pwrite;
	wire wr_ctl  = wr && (paddr == timer_time_base_pkg::OFS_MAIN_CONTROL);
	wire wr_evt  = wr && (paddr == timer_time_base_pkg::OFS_EVENT_REQUEST);
	wire wr_flg  = wr && (paddr == timer_time_base_pkg::OFS_TIMER_FLAGS);
	wire wr_cnt  = wr && (paddr == timer_time_base_pkg::OFS_COUNT_VALUE);
	wire wr_psc  = wr && (paddr == timer_time_base_pkg::OFS_PRESCALE);
	wire wr_arr  = wr && (paddr == timer_time_base_pkg::OFS_RELOAD_VALUE);
	wire wr_opt  = wr && (paddr == timer_time_base_pkg::OFS_TIMER_OPTION);
	wire wr_chs  = wr && (paddr == timer_time_base_pkg::OFS_CHANNEL_SET);
	wire mapped  = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);

	// force_refresh is never stored, so it reads back as zero
	wire force_refresh = wr_evt && pwdata[timer_time_base_pkg::EVT_FORCE];

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			timer_time_base_pkg::OFS_MAIN_CONTROL:  rd_mux = {25'h0, ctl_reg};
			timer_time_base_pkg::OFS_TIMER_FLAGS:   rd_mux = {31'h0, flag_reg};
			timer_time_base_pkg::OFS_COUNT_VALUE:   rd_mux = {16'h0, cnt_reg};
			timer_time_base_pkg::OFS_PRESCALE:      rd_mux = {28'h0, psc_buf_reg};
			timer_time_base_pkg::OFS_RELOAD_VALUE:  rd_mux = {16'h0, arr_buf_reg};
			timer_time_base_pkg::OFS_TIMER_OPTION:  rd_mux = {27'h0, mask_en_reg, remap_reg};
			timer_time_base_pkg::OFS_CHANNEL_SET:   rd_mux = {24'h0, chs_reg};
			default:                                rd_mux = 32'h0000_0000;
		endcase
	end

	// no wait states: answer computed in the setup cycle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable && !pready;
			prdata  <= (psel && !penable) ? rd_mux : prdata;
			pslverr <= psel && !penable && !mapped;
		end
	end

	// clock source: internal clock, or synchronised external edges
	wire ext_gated  = ext_s2_reg[0] && (ext_s2_reg[1] || !mask_en_reg);
	wire ext_rise   = ext_gated && !ext_prev_reg;
	wire psc_in     = ctl_reg.ext_mode ? ext_rise : 1'b1;
	// prescaler wraps at 2^exp - 1
	wire [W-1:0] psc_top = W'((32'h1 << psc_act_reg) - 32'h1);
	wire psc_wrap   = psc_cnt_reg == psc_top;
	// count clock only with the delayed enable
	wire count_tick = internal_count_enable_reg && psc_in && psc_wrap;

	wire up_dir     = !ctl_reg.dir_down;
	wire cnt_eq_arr = cnt_reg == arr_act_reg;
	wire [W-1:0] arr_m1 = arr_act_reg - 16'h0001;
	wire ovf_up     = count_tick && !ctl_reg.center_mode && up_dir && cnt_eq_arr;
	wire udf_dn     = count_tick && !ctl_reg.center_mode && !up_dir && (cnt_reg == 16'h0000);
	wire ovf_ctr    = count_tick && ctl_reg.center_mode && up_dir && (arr_act_reg != 16'h0000)
		&& (cnt_reg == arr_m1);
	wire udf_ctr    = count_tick && ctl_reg.center_mode && !up_dir && (cnt_reg == 16'h0001);
	wire hw_event   = ovf_up || udf_dn || ovf_ctr || udf_ctr;
	// inhibit stops only hardware updates; center mode keeps counting
	wire hw_update  = hw_event && !ctl_reg.update_inhibit;
	wire update_ev  = hw_update || force_refresh;
	// software update raises no flag while source-only is set
	wire flag_set   = hw_update || (force_refresh && !ctl_reg.refresh_source_only);
	wire flag_clr   = wr_flg && pwdata[timer_time_base_pkg::FLG_REFR];
	// reload value in force for the next period
	wire [W-1:0] arr_new = (update_ev || !ctl_reg.reload_buffer_enable) ? arr_buf_reg
		: arr_act_reg;

	// counter next value
	always_comb begin
		cnt_next = cnt_reg;
		if (force_refresh) begin
			// down mode reloads, up and center restart at zero
			cnt_next = (ctl_reg.dir_down && !ctl_reg.center_mode) ? arr_new : 16'h0000;
		end else if (wr_cnt) begin
			cnt_next = pwdata[W-1:0];
		end else if (count_tick) begin
			if (ctl_reg.center_mode) begin
				if (arr_act_reg == 16'h0000) begin
					cnt_next = 16'h0000;
				end else if (ovf_ctr) begin
					// top of the swing takes the reload value just made active
					cnt_next = arr_new;
				end else if (up_dir) begin
					cnt_next = cnt_reg + 16'h0001;
				end else begin
					cnt_next = cnt_reg - 16'h0001;
				end
			end else if (up_dir) begin
				cnt_next = cnt_eq_arr ? 16'h0000 : cnt_reg + 16'h0001;
			end else begin
				cnt_next = (cnt_reg == 16'h0000) ? arr_new : cnt_reg - 16'h0001;
			end
		end
	end

	// control register: direction is hardware-owned in center mode
	timer_time_base_pkg::main_control_s ctl_wr;
	assign ctl_wr = {pwdata[timer_time_base_pkg::CTL_EXT],
		pwdata[timer_time_base_pkg::CTL_RELOAD_BUFFER_ENABLE], pwdata[timer_time_base_pkg::CTL_CENTER],
		pwdata[timer_time_base_pkg::CTL_DIR], pwdata[timer_time_base_pkg::CTL_SRC],
		pwdata[timer_time_base_pkg::CTL_INHIB], pwdata[timer_time_base_pkg::CTL_RUN]};
	logic dir_hw;
	always_comb begin
		dir_hw = ctl_reg.dir_down;
		if (force_refresh && ctl_reg.center_mode) begin
			dir_hw = 1'b0;
		end else if (ovf_ctr) begin
			dir_hw = 1'b1;
		end else if (udf_ctr) begin
			dir_hw = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_reg <= '0;
		end else if (wr_ctl) begin
			ctl_reg <= ctl_wr;
			if (ctl_wr.center_mode && ctl_reg.center_mode) begin
				ctl_reg.dir_down <= dir_hw;
			end
		end else begin
			ctl_reg.dir_down <= ctl_reg.center_mode ? dir_hw : ctl_reg.dir_down;
		end
	end

	// time base core; no debug-halt input, so it never freezes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg      <= 16'h0000;
			internal_count_enable_reg   <= 1'b0;
			psc_cnt_reg  <= 16'h0000;
			ext_prev_reg <= 1'b0;
		end else begin
			cnt_reg      <= cnt_next;
			internal_count_enable_reg   <= ctl_reg.count_run_bit;
			ext_prev_reg <= ext_gated;
			if (force_refresh) begin
				psc_cnt_reg <= 16'h0000;
			end else if (internal_count_enable_reg && psc_in) begin
				psc_cnt_reg <= psc_wrap ? 16'h0000 : psc_cnt_reg + 16'h0001;
			end
		end
	end

	// buffers and shadows
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			arr_buf_reg <= timer_time_base_pkg::RELOAD_RST;
			arr_act_reg <= timer_time_base_pkg::RELOAD_RST;
			psc_buf_reg <= 4'h0;
			psc_act_reg <= 4'h0;
		end else begin
			if (wr_arr) begin
				arr_buf_reg <= pwdata[W-1:0];
			end
			if (wr_psc) begin
				psc_buf_reg <= pwdata[EW-1:0];
			end
			arr_act_reg <= arr_new;
			if (update_ev) begin
				psc_act_reg <= psc_buf_reg;
			end
		end
	end

	// refresh flag: a set in the clearing cycle wins
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_reg              <= 1'b0;
			refresh_event         <= 1'b0;
			internal_count_enable <= 1'b0;
		end else begin
			flag_reg              <= flag_set || (flag_reg && !flag_clr);
			refresh_event         <= update_ev;
			internal_count_enable <= internal_count_enable_reg;
		end
	end

	// option and channel registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			remap_reg   <= '0;
			mask_en_reg <= 1'b0;
			chs_reg     <= '0;
		end else begin
			if (wr_opt) begin
				remap_reg   <= pwdata[timer_time_base_pkg::OPT_REMAP +: NCHAN];
				mask_en_reg <= pwdata[timer_time_base_pkg::OPT_MSKEN];
			end
			if (wr_chs) begin
				chs_reg.chan_is_output <= pwdata[timer_time_base_pkg::CHS_OUT +: NCHAN];
				chs_reg.chan_enable    <= pwdata[timer_time_base_pkg::CHS_EN +: NCHAN];
			end
		end
	end

	// per-channel pin routing; the first timer simply leaves remap at zero
	for (genvar c = 0; c < NCHAN; c++) begin : g_chan
		wire drive = chs_reg.chan_is_output[c] && chs_reg.chan_enable[c];
		wire own_a = drive && !remap_reg[c];
		wire own_b = drive && remap_reg[c];
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				chan_in[c]        <= 1'b0;
				pa_out[c]         <= 1'b0;
				pb_out[c]         <= 1'b0;
				pa_timer_owned[c] <= 1'b0;
				pb_timer_owned[c] <= 1'b0;
			end else begin
				chan_in[c]        <= remap_reg[c] ? pb_s2_reg[c] : pa_s2_reg[c];
				pa_out[c]         <= own_a ? chan_out[c] : periph_pa_out[c];
				pb_out[c]         <= own_b ? chan_out[c] : periph_pb_out[c];
				pa_timer_owned[c] <= own_a;
				pb_timer_owned[c] <= own_b;
			end
		end
		pin_owner_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
			own_a |=> pa_timer_owned[c] && pa_out[c] == $past(chan_out[c]))
			else $error("timer output lost its pin");
		remap_in_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
			remap_reg[c] |=> chan_in[c] == $past(pb_s2_reg[c]))
			else $error("remapped channel not read from port B");
	end

	// checks
	run_delay_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(ctl_reg.count_run_bit) |-> !internal_count_enable_reg ##1 internal_count_enable_reg)
		else $error("count enable not one cycle after run bit");
	up_wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ovf_up && !force_refresh && !wr_cnt |=> cnt_reg == 16'h0000)
		else $error("up counter did not wrap to zero");
	down_reload_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		udf_dn && !force_refresh && !wr_cnt |=> cnt_reg == $past(arr_new))
		else $error("down counter did not reload");
	inhibit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		hw_event && ctl_reg.update_inhibit && !force_refresh |=> !refresh_event)
		else $error("update raised while inhibited");
	src_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		force_refresh && ctl_reg.refresh_source_only && !hw_update && !flag_reg |=> !flag_reg)
		else $error("software update set flag with source-only");
	psc_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!update_ev |=> $stable(psc_act_reg))
		else $error("prescale ratio changed without update");
	sw_restart_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		force_refresh && !ctl_reg.dir_down |=> cnt_reg == 16'h0000 && psc_cnt_reg == 16'h0000)
		else $error("software update did not restart counters");
	center_dir_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ovf_ctr && !force_refresh && !(wr_ctl && !ctl_wr.center_mode)
		|=> ctl_reg.dir_down ##0 refresh_event == $past(hw_update))
		else $error("center mode direction not turned at top");
	arr_buffer_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ctl_reg.reload_buffer_enable && !update_ev |=> $stable(arr_act_reg))
		else $error("buffered reload changed without update");
	flag_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		flag_set |=> flag_reg)
		else $error("refresh flag not set by update");
	psc_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		update_ev |=> psc_act_reg == $past(psc_buf_reg))
		else $error("prescale ratio not loaded on update");
	arr_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!ctl_reg.reload_buffer_enable || update_ev |=> arr_act_reg == $past(arr_buf_reg))
		else $error("reload shadow did not take the buffer");
	down_sw_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		force_refresh && ctl_reg.dir_down && !ctl_reg.center_mode
		|=> cnt_reg == $past(arr_buf_reg) && psc_cnt_reg == 16'h0000)
		else $error("software update did not reload down counter");
	center_sw_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		force_refresh && ctl_reg.center_mode
		|=> cnt_reg == 16'h0000 && psc_cnt_reg == 16'h0000 && !ctl_reg.dir_down)
		else $error("center mode software update did not restart upward");
	no_tick_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!internal_count_enable_reg && !force_refresh && !wr_cnt |=> $stable(cnt_reg))
		else $error("counter moved while disabled");
	center_bottom_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		udf_ctr && !force_refresh && !wr_cnt |=> cnt_reg == 16'h0000)
		else $error("center mode did not reach zero after underflow");
	dir_locked_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_ctl && ctl_reg.center_mode && ctl_wr.center_mode && !ovf_ctr && !udf_ctr
		|=> ctl_reg.dir_down == $past(ctl_reg.dir_down))
		else $error("direction written in center mode");
endmodule // timer_time_base

/* verif/testbench.sv */
// self-checking bench for the timer time-base unit: apb access, event timing, pins
// assumes the design package is compiled first; the bench drives every design input
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module testbench;
	localparam logic [7:0]  A_CTL = timer_time_base_pkg::OFS_MAIN_CONTROL;
	localparam logic [7:0]  A_EVT = timer_time_base_pkg::OFS_EVENT_REQUEST;
	localparam logic [7:0]  A_FLG = timer_time_base_pkg::OFS_TIMER_FLAGS;
	localparam logic [7:0]  A_CNT = timer_time_base_pkg::OFS_COUNT_VALUE;
	localparam logic [7:0]  A_PSC = timer_time_base_pkg::OFS_PRESCALE;
	localparam logic [7:0]  A_ARR = timer_time_base_pkg::OFS_RELOAD_VALUE;
	localparam logic [7:0]  A_OPT = timer_time_base_pkg::OFS_TIMER_OPTION;
	localparam logic [7:0]  A_CHS = timer_time_base_pkg::OFS_CHANNEL_SET;
	localparam logic [31:0] RUN   = 32'h1 << timer_time_base_pkg::CTL_RUN;
	localparam logic [31:0] INHIB = 32'h1 << timer_time_base_pkg::CTL_INHIB;
	localparam logic [31:0] SRC   = 32'h1 << timer_time_base_pkg::CTL_SRC;
	localparam logic [31:0] DOWN  = 32'h1 << timer_time_base_pkg::CTL_DIR;
	localparam logic [31:0] CENT  = 32'h1 << timer_time_base_pkg::CTL_CENTER;
	localparam logic [31:0] BUFEN = 32'h1 << timer_time_base_pkg::CTL_RELOAD_BUFFER_ENABLE;
	localparam logic [31:0] EXT   = 32'h1 << timer_time_base_pkg::CTL_EXT;
	logic        ref_clk, rst_b, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic        rerr, ext_clock_in, clock_gate_in, refresh_event, internal_count_enable;
	logic [3:0]  pa_in, pb_in, chan_out, periph_pa_out, periph_pb_out, chan_in;
	logic [3:0]  pa_out, pa_timer_owned, pb_out, pb_timer_owned, remap;
	logic [15:0] mx;
	int          n_mismatch, n_compared, c, c1, np, j;
	logic [7:0]  ra[6] = '{A_CTL, A_ARR, A_PSC, A_CNT, A_FLG, A_EVT};
	logic [31:0] rv[6] = '{32'h0, 32'h0000FFFF, 32'h0, 32'h0, 32'h0, 32'h0};

	timer_time_base dut (
		.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.ext_clock_in(ext_clock_in), .clock_gate_in(clock_gate_in), .pa_in(pa_in),
		.pb_in(pb_in), .chan_out(chan_out), .periph_pa_out(periph_pa_out),
		.periph_pb_out(periph_pb_out), .chan_in(chan_in), .pa_out(pa_out),
		.pa_timer_owned(pa_timer_owned), .pb_out(pb_out), .pb_timer_owned(pb_timer_owned),
		.refresh_event(refresh_event), .internal_count_enable(internal_count_enable)
	);

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// entered just after a rising edge; leaves one idle cycle so strobes never double-assign
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge ref_clk);
			if (pready === 1'b1) break;
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		if (i == 20) begin n_mismatch++; final_report(); end
		@(posedge ref_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	// cycles until the next refresh pulse; pulse is one cycle wide so each edge sees it once
	task automatic wait_evt(output int n);
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (refresh_event !== 1'b1 && n < 3000);
		if (n >= 3000) begin n_mismatch++; final_report(); end
	endtask

	task automatic ext_edges(input int n);
		repeat (n) begin
			ext_clock_in <= 1'b1;
			repeat (4) @(posedge ref_clk);
			ext_clock_in <= 1'b0;
			repeat (4) @(posedge ref_clk);
		end
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic count_max();
		mx = 16'h0;
		repeat (6) begin
			rd(A_CNT);
			if (rdat[15:0] > mx) mx = rdat[15:0];
		end
	endtask

	initial begin
		n_mismatch = 0; n_compared = 0;
		rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
		pwdata = 32'h0; ext_clock_in = 1'b0; clock_gate_in = 1'b0; pa_in = 4'h0;
		pb_in = 4'h0; chan_out = 4'h0; periph_pa_out = 4'h0; periph_pb_out = 4'h0;
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge ref_clk);
		for (j = 0; j < 6; j++) begin
			rd(ra[j]);
			`CHK(rdat, rv[j])
		end
		rd(8'h20);
		`CHK({rerr, rdat}, {1'b1, 32'h0})
		wr(8'h22, 32'hFFFF);
		`CHK(rerr, 1'b1)
		wr(A_CNT, 32'h1234);
		rd(A_CNT);
		`CHK(rdat, 32'h00001234)
		`CHK(internal_count_enable, 1'b0)
		wr(A_EVT, 32'h1);
		rd(A_CNT);
		`CHK(rdat, 32'h0)
		rd(A_FLG);
		`CHK(rdat, 32'h1)
		rd(A_EVT);
		`CHK(rdat, 32'h0)
		wr(A_FLG, 32'h1);
		rd(A_FLG);
		`CHK(rdat, 32'h0)
		wr(A_CTL, SRC);
		wr(A_CNT, 32'h5);
		wr(A_EVT, 32'h1);
		rd(A_FLG);
		`CHK(rdat, 32'h0)
		wr(A_ARR, 32'h3);
		wr(A_CTL, DOWN);
		wr(A_EVT, 32'h1);
		rd(A_CNT);
		`CHK(rdat, 32'h3)
		// up mode, ratio 4 loaded by a forced refresh: period (3+1)*4
		wr(A_PSC, 32'h2);
		wr(A_CTL, RUN);
		repeat (2) @(posedge ref_clk);
		`CHK(internal_count_enable, 1'b1)
		wr(A_EVT, 32'h1);
		wait_evt(c);
		wait_evt(c);
		`CHK(c, 16)
		wait_evt(c);
		wr(A_PSC, 32'h0);
		wait_evt(c);
		`CHK(c + 3, 16)
		wait_evt(c);
		`CHK(c, 4)
		wr(A_CTL, RUN | DOWN);
		wait_evt(c);
		wait_evt(c);
		`CHK(c, 4)
		wr(A_CTL, RUN | DOWN | BUFEN);
		wr(A_ARR, 32'h5);
		wait_evt(c);
		wait_evt(c);
		`CHK(c, 6)
		// center mode: two events per full swing of 2*5 steps
		wr(A_CTL, RUN | CENT | BUFEN);
		wait_evt(c);
		wait_evt(c);
		wait_evt(c1);
		wait_evt(c);
		`CHK(c1 + c, 10)
		// restart at zero: five ticks up to the top of the swing
		wr(A_EVT, 32'h1);
		wait_evt(c);
		`CHK(c, 5)
		wr(A_CTL, RUN | CENT | INHIB | BUFEN);
		repeat (2) @(posedge ref_clk);
		np = 0;
		repeat (40) begin
			@(posedge ref_clk);
			if (refresh_event === 1'b1) np++;
		end
		`CHK(np, 0)
		wr(A_CTL, RUN | INHIB | BUFEN);
		wr(A_ARR, 32'hFF);
		count_max();
		`CHK(mx <= 16'h5, 1'b1)
		wr(A_CTL, RUN | INHIB);
		count_max();
		`CHK(mx > 16'h5, 1'b1)
		wr(A_CTL, RUN | EXT);
		wr(A_ARR, 32'hFFFF);
		wr(A_CNT, 32'h0);
		ext_edges(5);
		rd(A_CNT);
		`CHK(rdat, 32'h5)
		wr(A_OPT, 32'h1 << timer_time_base_pkg::OPT_MSKEN);
		ext_edges(3);
		rd(A_CNT);
		`CHK(rdat, 32'h5)
		remap = 4'h5;
		wr(A_CTL, 32'h0);
		wr(A_OPT, {28'h0, remap});
		wr(A_CHS, 32'hFF);
		chan_out <= 4'hB; periph_pa_out <= 4'h6; periph_pb_out <= 4'h9;
		pa_in <= 4'h3; pb_in <= 4'h5;
		repeat (6) @(posedge ref_clk);
		`CHK({pa_timer_owned, pb_timer_owned}, {~remap, remap})
		`CHK(pa_out, (chan_out & ~remap) | (periph_pa_out & remap))
		`CHK(pb_out, (chan_out & remap) | (periph_pb_out & ~remap))
		`CHK(chan_in, (pb_in & remap) | (pa_in & ~remap))
		wr(A_CHS, 32'h0F);
		repeat (3) @(posedge ref_clk);
		`CHK({pa_timer_owned, pb_timer_owned, pa_out}, {8'h00, periph_pa_out})
		final_report();
	end
endmodule // testbench
